/* rtl/pch_pkg.sv */
package pch_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ = 10_000_000;
  // selection code width and program count
  localparam int unsigned SEL_W = 5;
  localparam int unsigned PROG_COUNT = 32;
  localparam int unsigned PROG_W = 6;
  // timing figures in their own units
  localparam int unsigned PULSE_MIN_MS = 5;
  localparam int unsigned SEL_WAIT_MS = 2;
  localparam int unsigned SEL_SETTLE_MS = 5;
  localparam int unsigned REACT_MAX_MS = 5;
  localparam int unsigned DONE_PULSE_S = 1;
  // derived cycle counts: minimums round up, maximums round down
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned SEL_WAIT_CYC = (SEL_WAIT_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned SEL_SETTLE_CYC = (SEL_SETTLE_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned REACT_MAX_CYC = (REACT_MAX_MS * CLK_HZ) / 1000;
  localparam int unsigned DONE_PULSE_CYC = DONE_PULSE_S * CLK_HZ;
  // counter width big enough for the one second pulse
  localparam int unsigned CNT_W = 24;
  // device operating states
  typedef enum logic [1:0] {
    PCH_IDLE,
    PCH_RUN,
    PCH_FAULT
  } pch_state_t;
  // host sequencing states
  typedef enum logic [2:0] {
    PCH_H_IDLE,
    PCH_H_SETTLE,
    PCH_H_PULSE,
    PCH_H_WAIT
  } pch_host_state_t;
endpackage

/* rtl/pch_if.sv */
`timescale 1ns/100ps
`default_nettype none
// discrete control port: controller drives inputs, device drives contacts
interface pch_if;
  import pch_pkg::*;
  logic [SEL_W-1:0] select_bits; // select_bit_low is bit 0, select_bit_high is bit 4
  logic launch_in; // start pulse
  logic stop_in; // stop pulse
  logic fault_clear_in; // error reset pulse
  logic ready_out; // prepared contact
  logic program_active_out; // program program_active_out contact
  logic done_out; // finished pulse contact
  logic fault_out; // error contact
  logic warn_out; // warning contact
  logic spare_out; // reserved contact
  modport device (
    input select_bits, launch_in, stop_in, fault_clear_in,
    output ready_out, program_active_out, done_out, fault_out, warn_out, spare_out
  );
  modport host (
    output select_bits, launch_in, stop_in, fault_clear_in,
    input ready_out, program_active_out, done_out, fault_out, warn_out, spare_out
  );
endinterface
`default_nettype wire

/* rtl/pch_filter.sv */
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser followed by a stability filter
module pch_filter #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned STABLE_CYC = 4
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_raw,
  output logic [WIDTH-1:0] o_clean,
  output logic [WIDTH-1:0] o_rise
);
  import pch_pkg::*;
  logic [WIDTH-1:0] meta_q; // first sync stage, read only by sync_q
  logic [WIDTH-1:0] sync_q; // second sync stage
  logic [WIDTH-1:0] clean_q; // accepted level
  logic [WIDTH-1:0] rise_q; // one-cycle pulse on accepted rise
  logic [CNT_W-1:0] cnt_q [WIDTH]; // per-bit stability counters

  // synchroniser: pins are asynchronous to i_mclk
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_raw;
      sync_q <= meta_q;
    end
  end

  // each bit must hold a new level for STABLE_CYC-1 cycles before it is taken
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        cnt_q[b] <= '0;
        clean_q[b] <= 1'b0;
        rise_q[b] <= 1'b0;
      end else begin
        rise_q[b] <= 1'b0;
        if (sync_q[b] == clean_q[b]) begin
          // level agrees: glitch counting starts over
          cnt_q[b] <= '0;
        end else if (cnt_q[b] >= CNT_W'(STABLE_CYC - 2)) begin
          // stable long enough, two sync cycles already spent
          clean_q[b] <= sync_q[b];
          rise_q[b] <= sync_q[b];
          cnt_q[b] <= '0;
        end else begin
          cnt_q[b] <= cnt_q[b] + CNT_W'(1);
        end
      end
    end
  end

  assign o_clean = clean_q;
  assign o_rise = rise_q;
endmodule
`default_nettype wire

/* rtl/pch_device.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - run program equal to code plus one
// - select bit 0 is LSB, bit 4 MSB
// - controller holds pulses at least 5 ms
// - controller waits 2 ms before start
// - controller allows 5 ms select settling
// - react within 5 ms of pulse rise; the code takes the 5 ms filter time plus a few cycles
// - finished pulse lasts exactly one second
// - start while prepared runs, sets active
// - normal finish clears active, pulses finished
// - bad program data gives error, no run
// - stop aborts: active off, prepared on
// - warning shown, never alters program
// - error during run aborts, no finished
// - error reset clears error, prepared on
// - prepared only when request acceptable
// - start works whatever panel display shows
// - asserted means contact conducts, current flows
module pch_device #(
  parameter int unsigned PULSE_CYC = pch_pkg::PULSE_MIN_CYC,
  parameter int unsigned DONE_CYC = pch_pkg::DONE_PULSE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  pch_if.device port,
  input wire logic i_prog_done, // program engine finished normally
  input wire logic i_prog_bad, // selected program data unusable
  input wire logic i_fault, // device error condition (level)
  input wire logic i_warn, // device warning condition (level)
  output logic o_prog_go, // one-cycle launch of the engine
  output logic o_prog_abort, // one-cycle abort of the engine
  output logic [pch_pkg::PROG_W-1:0] o_prog_num, // program 1..32
  output logic o_program_active_out
);
  import pch_pkg::*;
  pch_state_t state_q; // operating state
  logic [SEL_W-1:0] sel_clean; // filtered selection code
  logic [2:0] ctl_clean; // filtered start/stop/clear
  logic [2:0] ctl_rise; // accepted rising edges
  logic [CNT_W-1:0] done_cnt_q; // finished pulse timer
  logic done_q, ready_q, active_q, fault_q, warn_q;
  logic go_q, abort_q;
  logic [PROG_W-1:0] num_q;
  logic sel_ok_q;

  // all inputs conduct-means-one, so no inversion is needed
  pch_filter #(.WIDTH(SEL_W), .STABLE_CYC(PULSE_CYC)) u_sel (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_raw(port.select_bits),
    .o_clean(sel_clean),
    .o_rise()
  );
  pch_filter #(.WIDTH(3), .STABLE_CYC(PULSE_CYC)) u_ctl (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_raw({port.fault_clear_in, port.stop_in, port.launch_in}),
    .o_clean(ctl_clean),
    .o_rise(ctl_rise)
  );

  // program number: binary code, bit 0 least significant, plus one
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      num_q <= PROG_W'(1);
      sel_ok_q <= 1'b0;
    end else begin
      num_q <= {1'b0, sel_clean} + PROG_W'(1);
      sel_ok_q <= 1'b1;
    end
  end

  // operating state; faults outrank stop, stop outranks finish
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= PCH_IDLE;
      go_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      abort_q <= 1'b0;
      unique case (state_q)
        PCH_IDLE: begin
          if (i_fault) begin
            state_q <= PCH_FAULT;
          end else if (ctl_rise[0] && ready_q) begin
            // start accepted regardless of panel mode
            if (i_prog_bad) begin
              state_q <= PCH_FAULT; // never enters run
            end else begin
              state_q <= PCH_RUN;
              go_q <= 1'b1;
            end
          end
        end
        PCH_RUN: begin
          if (i_fault) begin
            state_q <= PCH_FAULT; // error interrupts the program
            abort_q <= 1'b1;
          end else if (ctl_rise[1]) begin
            state_q <= PCH_IDLE; // stop: back to prepared, no error
            abort_q <= 1'b1;
          end else if (i_prog_done) begin
            state_q <= PCH_IDLE; // normal finish
          end
        end
        PCH_FAULT: begin
          // clear only once i_fault has gone; i_prog_bad is not checked
          if (ctl_rise[2] && !i_fault) begin
            state_q <= PCH_IDLE;
          end
        end
      endcase
    end
  end

  // finished pulse: exactly DONE_CYC cycles, only on a normal finish
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
      done_cnt_q <= '0;
    end else if (state_q == PCH_RUN && !i_fault && !ctl_rise[1] && i_prog_done) begin
      done_q <= 1'b1;
      done_cnt_q <= CNT_W'(DONE_CYC - 1);
    end else if (done_cnt_q != '0) begin
      done_cnt_q <= done_cnt_q - CNT_W'(1);
    end else begin
      done_q <= 1'b0;
    end
  end

  // contacts registered from state, one cycle after it
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ready_q <= 1'b0;
      active_q <= 1'b0;
      fault_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      // prepared only when idle, fault-free and selection valid
      ready_q <= (state_q == PCH_IDLE) && !i_fault && sel_ok_q && !go_q;
      // active drops on the edge the finished pulse starts, so the pulse never begins while active is on
      active_q <= (state_q == PCH_RUN) && !i_prog_done;
      fault_q <= (state_q == PCH_FAULT);
      // warning only displayed, state machine ignores it
      warn_q <= i_warn;
    end
  end

  assign port.ready_out = ready_q;
  assign port.program_active_out = active_q;
  assign port.done_out = done_q;
  assign port.fault_out = fault_q;
  assign port.warn_out = warn_q;
  assign port.spare_out = 1'b0;
  assign o_prog_go = go_q;
  assign o_prog_abort = abort_q;
  assign o_prog_num = num_q;
  assign o_program_active_out = active_q;
endmodule
`default_nettype wire

/* rtl/pch_host.sv */
`timescale 1ns/100ps
`default_nettype none
// controller end: sets the code and waits before a start, then pulses one control input
module pch_host #(
  parameter int unsigned PULSE_CYC = pch_pkg::PULSE_MIN_CYC,
  parameter int unsigned SETTLE_CYC = pch_pkg::SEL_SETTLE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  pch_if.host port,
  input wire logic [pch_pkg::SEL_W-1:0] i_code, // program number minus one
  input wire logic i_start, // request a launch (pulse)
  input wire logic i_stop, // request a stop (pulse)
  input wire logic i_clear, // request an error reset (pulse)
  output logic o_busy,
  output logic o_ready,
  output logic o_active,
  output logic o_done,
  output logic o_fault,
  output logic o_warn
);
  import pch_pkg::*;
  pch_host_state_t st_q;
  logic [SEL_W-1:0] code_q;
  logic [2:0] which_q; // {clear, stop, start}
  logic [2:0] drive_q;
  logic [CNT_W-1:0] cnt_q;
  logic [5:0] meta_q, sync_q; // contacts are from outside the domain

  // sequencer: settle for select change, then hold pulse, then recover gap
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_q <= PCH_H_IDLE;
      code_q <= '0;
      which_q <= '0;
      drive_q <= '0;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        PCH_H_IDLE: begin
          if (i_start) begin
            code_q <= i_code;
            which_q <= 3'h1;
            cnt_q <= CNT_W'(SETTLE_CYC - 1); // beyond the 2 ms minimum
            st_q <= PCH_H_SETTLE;
          end else if (i_stop || i_clear) begin
            which_q <= i_stop ? 3'h2 : 3'h4;
            cnt_q <= CNT_W'(PULSE_CYC - 1);
            drive_q <= i_stop ? 3'h2 : 3'h4;
            st_q <= PCH_H_PULSE;
          end
        end
        PCH_H_SETTLE: begin
          if (cnt_q == '0) begin
            drive_q <= which_q;
            cnt_q <= CNT_W'(PULSE_CYC - 1);
            st_q <= PCH_H_PULSE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        PCH_H_PULSE: begin
          // hold at least the minimum width
          if (cnt_q == '0) begin
            drive_q <= '0;
            cnt_q <= CNT_W'(PULSE_CYC - 1);
            st_q <= PCH_H_WAIT;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        PCH_H_WAIT: begin
          // low gap so the next pulse is seen as a new rise
          if (cnt_q == '0) begin
            st_q <= PCH_H_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // contact synchroniser and registered status
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {port.warn_out, port.fault_out, port.done_out,
                 port.program_active_out, port.ready_out, 1'b0};
      sync_q <= meta_q;
    end
  end

  assign port.select_bits = code_q; // code is number minus one
  assign port.launch_in = drive_q[0];
  assign port.stop_in = drive_q[1];
  assign port.fault_clear_in = drive_q[2];
  assign o_busy = (st_q != PCH_H_IDLE);
  assign o_ready = sync_q[1];
  assign o_active = sync_q[2];
  assign o_done = sync_q[3];
  assign o_fault = sync_q[4];
  assign o_warn = sync_q[5];
endmodule
`default_nettype wire

/* tb/pch_props.sv */
`timescale 1ns/100ps
`default_nettype none
// watches the contacts and pulses on the port between host and device
module pch_props #(
  parameter int unsigned PULSE_CYC = 8,
  parameter int unsigned DONE_CYC = 16
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic launch_in,
  input wire logic stop_in,
  input wire logic fault_clear_in,
  input wire logic ready_out,
  input wire logic program_active_out,
  input wire logic done_out,
  input wire logic fault_out
);
  import pch_pkg::*;
  // reaction bound: filter time plus a few cycles of pipeline
  localparam int REACT_CYC = PULSE_CYC + 8;
  logic [23:0] done_cnt_q; // cycles the finished contact has been on
  // length is judged at the fall, since the pulse is too long to unroll
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || !done_out) begin
      done_cnt_q <= '0;
    end else begin
      done_cnt_q <= done_cnt_q + 24'h000001;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_done_len; $fell(done_out) |-> done_cnt_q == 24'(DONE_CYC); endproperty
  property p_done_max; done_out |-> done_cnt_q < 24'(DONE_CYC); endproperty
  property p_done_end; $rose(done_out) |-> !program_active_out && !fault_out; endproperty
  property p_fault_off; fault_out |-> !ready_out && !program_active_out; endproperty
  property p_fault_nodone; $rose(fault_out) |-> (!done_out) [*4]; endproperty
  property p_launch; $rose(launch_in) && ready_out |-> ##[1:REACT_CYC] (program_active_out || fault_out); endproperty
  property p_stop; $rose(stop_in) && program_active_out |-> ##[1:REACT_CYC] (ready_out && !program_active_out);
  endproperty
  property p_clear; $fell(fault_out) |-> ready_out && $past(fault_clear_in, 8); endproperty
  property p_start_rdy; $rose(program_active_out) |-> $past(ready_out); endproperty
  a_done_len: assert property (p_done_len) else $error("finished pulse length wrong");
  a_done_max: assert property (p_done_max) else $error("finished pulse too long");
  a_done_end: assert property (p_done_end) else $error("finished pulse while active or faulted");
  a_fault_off: assert property (p_fault_off) else $error("error without ready and active off");
  a_fault_nodone: assert property (p_fault_nodone) else $error("finished pulse after error");
  a_launch: assert property (p_launch) else $error("start not reflected in time");
  a_stop: assert property (p_stop) else $error("stop did not abort in time");
  a_clear: assert property (p_clear) else $error("error left without reset or ready");
  a_start_rdy: assert property (p_start_rdy) else $error("program began while not ready");
  c_done: cover property ($rose(done_out));
  c_fault: cover property ($rose(fault_out));
  c_stop: cover property ($fell(program_active_out) && ready_out && !done_out);
endmodule
`default_nettype wire

/* tb/program_control_io_handshake_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// host and device face each other; the bench works both user sides
module program_control_io_handshake_tb_top;
  import pch_pkg::*;
  localparam int unsigned PC = 8; // shortened filter width
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [SEL_W-1:0] code = '0;
  logic rq_go = 1'b0, rq_stop = 1'b0, rq_clr = 1'b0; // host requests
  logic fin = 1'b0, bad = 1'b0, flt = 1'b0, wrn = 1'b0; // engine side
  logic busy, h_rdy, h_act, h_flt, h_wrn, go, abort, go2;
  logic [PROG_W-1:0] num, got_num;
  logic [7:0] go_cnt = '0, ab_cnt = '0, dn_cnt = '0, go2_cnt = '0; // event tallies
  int failures = 0, compares = 0, cyc = 0;
  always #50 i_mclk = ~i_mclk; // 10 MHz
  pch_if u_pch_if();
  pch_if u_pch_if_2(); // second port, driven raw to test the input filter
  pch_host #(.PULSE_CYC(PC), .SETTLE_CYC(8)) u_pch_host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .port(u_pch_if.host), .i_code(code), .i_start(rq_go), .i_stop(rq_stop), .i_clear(rq_clr), .o_busy(busy),
    .o_ready(h_rdy), .o_active(h_act), .o_done(), .o_fault(h_flt), .o_warn(h_wrn));
  pch_device #(.PULSE_CYC(PC), .DONE_CYC(16)) u_pch_device (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .port(u_pch_if.device), .i_prog_done(fin), .i_prog_bad(bad), .i_fault(flt), .i_warn(wrn),
    .o_prog_go(go), .o_prog_abort(abort), .o_prog_num(num), .o_program_active_out());
  pch_device #(.PULSE_CYC(PC), .DONE_CYC(16)) u_pch_device_2 (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .port(u_pch_if_2.device), .i_prog_done(fin), .i_prog_bad(bad), .i_fault(1'b0), .i_warn(wrn),
    .o_prog_go(go2), .o_prog_abort(), .o_prog_num(), .o_program_active_out());
  pch_props #(.PULSE_CYC(PC), .DONE_CYC(16)) u_pch_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .launch_in(u_pch_if.launch_in), .stop_in(u_pch_if.stop_in), .fault_clear_in(u_pch_if.fault_clear_in),
    .ready_out(u_pch_if.ready_out), .program_active_out(u_pch_if.program_active_out),
    .done_out(u_pch_if.done_out), .fault_out(u_pch_if.fault_out));
  // tallies one-cycle events and finished-pulse cycles, and cuts a hang short
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (go === 1'b1) begin
      go_cnt <= go_cnt + 8'h01;
      got_num <= num;
    end
    if (abort === 1'b1) ab_cnt <= ab_cnt + 8'h01;
    if (u_pch_if.done_out === 1'b1) dn_cnt <= dn_cnt + 8'h01;
    if (go2 === 1'b1) go2_cnt <= go2_cnt + 8'h01;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end
  // inputs change a fixed delay after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle request (0 start, 1 stop, 2 reset), then wait out the host
  task automatic ask(input int k);
    int i;
    rq_go = (k == 0);
    rq_stop = (k == 1);
    rq_clr = (k == 2);
    step(1);
    {rq_go, rq_stop, rq_clr} = 3'h0;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      step(1);
      i++;
    end
    step(6); // contacts pass two sync stages
  endtask
  // normal finish from the engine, then the timed finished pulse
  task automatic finish();
    fin = 1'b1;
    step(1);
    fin = 1'b0;
    step(30);
    chk(dn_cnt, 8'h10);
    chk(u_pch_if.program_active_out, 1'b0);
  endtask
  task automatic t_sel(input logic [4:0] c);
    code = c;
    go_cnt = '0;
    dn_cnt = '0;
    ask(0);
    chk(u_pch_if.select_bits, c);
    chk(go_cnt, 8'h01);
    chk(got_num, c + 8'h01);
    chk(h_act, 1'b1);
    finish();
    chk(u_pch_if.ready_out, 1'b1);
    chk(h_rdy, 1'b1);
    $display("test select %0d done", c);
  endtask
  task automatic t_stop();
    ask(0);
    ab_cnt = '0;
    dn_cnt = '0;
    ask(1);
    chk({u_pch_if.program_active_out, u_pch_if.ready_out, u_pch_if.fault_out}, 8'h02);
    chk(dn_cnt, 8'h00);
    chk(ab_cnt, 8'h01);
    $display("test stop done");
  endtask
  // fault from bad data, or during a run; reset refused while the run fault stays, taken with bad data still set
  task automatic t_fault(input logic bad_data);
    bad = bad_data;
    dn_cnt = '0;
    ask(0);
    flt = !bad_data;
    step(6);
    chk({u_pch_if.program_active_out, u_pch_if.ready_out, u_pch_if.fault_out}, 8'h01);
    chk(dn_cnt, 8'h00);
    chk(h_flt, 1'b1);
    ask(2);
    chk(u_pch_if.fault_out, !bad_data);
    {bad, flt} = 2'h0;
    ask(2);
    chk({u_pch_if.ready_out, u_pch_if.fault_out}, 8'h02);
    $display("test fault done");
  endtask
  task automatic t_warn();
    dn_cnt = '0;
    ask(0);
    wrn = 1'b1;
    step(6);
    chk({u_pch_if.warn_out, h_wrn, u_pch_if.program_active_out}, 8'h07);
    wrn = 1'b0;
    finish();
    $display("test warning done");
  endtask
  // short pulse is dropped, full-width pulse is taken
  task automatic t_glitch(input int w, input logic [7:0] exp);
    u_pch_if_2.launch_in = 1'b1;
    step(w);
    u_pch_if_2.launch_in = 1'b0;
    step(20);
    chk(go2_cnt, exp);
    $display("test width %0d done", w);
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {u_pch_if_2.select_bits, u_pch_if_2.launch_in, u_pch_if_2.stop_in, u_pch_if_2.fault_clear_in} = '0;
    step(4);
    i_sys_rst = 1'b0;
    step(4);
    t_sel(5'h00);
    t_sel(5'h01);
    t_sel(5'h10);
    t_sel(5'h1F);
    t_stop();
    t_fault(1'b1);
    t_fault(1'b0);
    t_warn();
    t_glitch(PC - 3, 8'h00);
    t_glitch(PC + 2, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
